// ===== common/erz_pkg.sv
// constants for the eeprom zone lock command engine
package erz_pkg;
	// zone geometry: four zones of 256 bits (32 bytes) each
	localparam int ZONES = 4;
	localparam int ZONE_BITS = 256;
	localparam int ZONE_BYTES = ZONE_BITS / 8;
	localparam int ARR_AW = 7;
	localparam logic [6:0] ZONE1_BASE = 7'h20;
	localparam logic [6:0] ZONE2_BASE = 7'h40;
	localparam logic [6:0] ZONE3_BASE = 7'h60;
	localparam int ZONE_MSB = 6;
	localparam int ZONE_LSB = 5;
	// lock register addresses, lower nibble of the address byte
	localparam logic [3:0] ZONE0_LOCK_ADDR = 4'h1;
	localparam logic [3:0] ZONE1_LOCK_ADDR = 4'h2;
	localparam logic [3:0] ZONE2_LOCK_ADDR = 4'h4;
	localparam logic [3:0] ZONE3_LOCK_ADDR = 4'h8;
	localparam logic [3:0] LOCK_RESET = 4'h0;
	// opcodes in the upper nibble of the device address byte
	localparam logic [3:0] OP_ZONE_LOCK = 4'h7;
	localparam logic [3:0] OP_FREEZE = 4'h1;
	localparam logic [3:0] OP_ARRAY = 4'ha;
	// fixed bytes
	localparam logic [7:0] LOCK_SET_DATA = 8'hff;
	localparam logic [7:0] RD_UNLOCKED = 8'h00;
	localparam logic [7:0] RD_LOCKED = 8'hff;
	localparam logic [7:0] FREEZE_ADDR = 8'h55;
	localparam logic [7:0] FREEZE_DATA = 8'haa;
	// self-timed write time of the lock cells
	localparam int CLK_PERIOD_NS = 5;
	localparam int SELF_TIMED_WRITE_TIME_NS = 1000000;
	localparam int SELF_TIMED_WRITE_CYCLES =
		(SELF_TIMED_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// command engine states
	typedef enum logic [3:0] {
		ERZ_IDLE = 4'h0,
		ERZ_DEVADDR = 4'h1,
		ERZ_LK_ADDR = 4'h2,
		ERZ_LK_DATA = 4'h3,
		ERZ_LK_DONE = 4'h4,
		ERZ_FZ_ADDR = 4'h5,
		ERZ_FZ_DATA = 4'h6,
		ERZ_FZ_DONE = 4'h7,
		ERZ_AW_ADDR = 4'h8,
		ERZ_AW_DATA = 4'h9,
		ERZ_IGNORE = 4'ha,
		ERZ_BUSY = 4'hb
	} erz_state_t;
endpackage : erz_pkg

// ===== rtl/erz_zone_lock.sv
// zone lock, lock query, freeze and array write guard of the serial eeprom
`timescale 1ns/1ps
module erz_zone_lock #(
	parameter int WR_CYCLES = erz_pkg::SELF_TIMED_WRITE_CYCLES,
	parameter logic [2:0] SLAVE_ADDR = 3'h0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// framed bytes from the single-wire bit engine
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	// answers to the bit engine
	output logic o_ack_valid,
	output logic o_nack,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_busy,
	// nonvolatile lock cells
	input wire logic [erz_pkg::ZONES-1:0] i_nv_lock,
	input wire logic i_nv_frozen,
	output logic o_nv_set_lock,
	output logic [erz_pkg::ZONES-1:0] o_nv_lock_sel,
	output logic o_nv_set_freeze,
	// array write port
	output logic o_arr_wr_en,
	output logic [erz_pkg::ARR_AW-1:0] o_arr_addr,
	output logic [7:0] o_arr_data
);
	localparam int CW = $clog2(WR_CYCLES + 1);

	// refuse settings the timer or the zone map cannot serve
	initial begin
		if (WR_CYCLES < 1) begin
			$error("WR_CYCLES must be at least one");
		end
		if (erz_pkg::ZONES * erz_pkg::ZONE_BYTES != (1 << erz_pkg::ARR_AW)) begin
			$error("zone map must cover the whole array");
		end
	end

	// command engine state and write timer
	erz_pkg::erz_state_t state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	// latched lock register selection
	logic [erz_pkg::ZONES-1:0] sel_r, sel_nxt;
	logic sel_ok_r, sel_ok_nxt;
	// answers handed back to the bit engine
	logic ack_valid_r, ack_valid_nxt;
	logic nack_r, nack_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	// programming pulses for the nonvolatile cells
	logic set_lock_r, set_lock_nxt;
	logic set_freeze_r, set_freeze_nxt;
	// array write path
	logic wr_en_r, wr_en_nxt;
	logic [erz_pkg::ARR_AW-1:0] addr_r, addr_nxt;
	logic [7:0] data_r, data_nxt;
	// output copies, so every port leaves a flop
	logic busy_r, busy_nxt;
	logic [erz_pkg::ARR_AW-1:0] waddr_r, waddr_nxt;
	// fields of the received byte, and zone of the running word address
	logic [3:0] op;
	logic [1:0] zone;
	logic addr_match;

	// opcode, slave address match and zone of the running word address
	assign op = i_byte[7:4];
	assign addr_match = (i_byte[3:1] == SLAVE_ADDR);
	assign zone = addr_r[erz_pkg::ZONE_MSB:erz_pkg::ZONE_LSB];

	// next state of the command engine
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sel_nxt = sel_r;
		sel_ok_nxt = sel_ok_r;
		ack_valid_nxt = 1'b0;
		nack_nxt = nack_r;
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		set_lock_nxt = 1'b0;
		set_freeze_nxt = 1'b0;
		wr_en_nxt = 1'b0;
		addr_nxt = addr_r;
		data_nxt = data_r;
		if (state_r == erz_pkg::ERZ_BUSY) begin
			// every line event is dropped until the write time ends
			if (cnt_r == CW'(1)) begin
				state_nxt = erz_pkg::ERZ_IDLE;
			end
			cnt_nxt = cnt_r - CW'(1);
		end else if (i_stop) begin
			// a completed lock or freeze sequence commits here, else abandon
			if (state_r == erz_pkg::ERZ_LK_DONE && !i_nv_frozen) begin
				set_lock_nxt = 1'b1;
				state_nxt = erz_pkg::ERZ_BUSY;
				cnt_nxt = CW'(WR_CYCLES);
			end else if (state_r == erz_pkg::ERZ_FZ_DONE) begin
				set_freeze_nxt = 1'b1;
				state_nxt = erz_pkg::ERZ_BUSY;
				cnt_nxt = CW'(WR_CYCLES);
			end else begin
				state_nxt = erz_pkg::ERZ_IDLE;
			end
			sel_ok_nxt = 1'b0;
		end else if (i_start) begin
			// keep a latched lock address only across the repeated start
			if (state_r != erz_pkg::ERZ_LK_DATA) begin
				sel_ok_nxt = 1'b0;
			end
			state_nxt = erz_pkg::ERZ_DEVADDR;
		end else if (i_byte_valid) begin
			ack_valid_nxt = 1'b1;
			nack_nxt = 1'b1;
			state_nxt = erz_pkg::ERZ_IGNORE;
			case (state_r)
				erz_pkg::ERZ_DEVADDR: begin
					// device address byte: the upper nibble picks the command
					if (!addr_match) begin
						ack_valid_nxt = 1'b0;
					end else if (op == erz_pkg::OP_ZONE_LOCK && !i_byte[0]) begin
						nack_nxt = 1'b0;
						state_nxt = erz_pkg::ERZ_LK_ADDR;
					end else if (op == erz_pkg::OP_ZONE_LOCK && sel_ok_r) begin
						nack_nxt = 1'b0;
						rd_valid_nxt = 1'b1;
						rd_data_nxt = |(i_nv_lock & sel_r) ? erz_pkg::RD_LOCKED
							: erz_pkg::RD_UNLOCKED;
					end else if (op == erz_pkg::OP_FREEZE && !i_byte[0]) begin
						nack_nxt = i_nv_frozen;
						if (!i_nv_frozen) begin
							state_nxt = erz_pkg::ERZ_FZ_ADDR;
						end
					end else if (op == erz_pkg::OP_ARRAY && !i_byte[0]) begin
						nack_nxt = 1'b0;
						state_nxt = erz_pkg::ERZ_AW_ADDR;
					end else if (op == erz_pkg::OP_ZONE_LOCK) begin
						nack_nxt = 1'b1;
					end else begin
						ack_valid_nxt = 1'b0;
					end
					sel_ok_nxt = 1'b0;
				end
				erz_pkg::ERZ_LK_ADDR: begin
					// upper nibble is don't care; only one-hot low nibbles select
					case (i_byte[3:0])
						erz_pkg::ZONE0_LOCK_ADDR,
						erz_pkg::ZONE1_LOCK_ADDR,
						erz_pkg::ZONE2_LOCK_ADDR,
						erz_pkg::ZONE3_LOCK_ADDR: begin
							nack_nxt = 1'b0;
							sel_nxt = i_byte[3:0];
							sel_ok_nxt = 1'b1;
							state_nxt = erz_pkg::ERZ_LK_DATA;
						end
						default: begin
							nack_nxt = 1'b1;
						end
					endcase
				end
				erz_pkg::ERZ_LK_DATA: begin
					// only FFh arms the lock write, and never once frozen
					if (i_byte == erz_pkg::LOCK_SET_DATA && !i_nv_frozen) begin
						nack_nxt = 1'b0;
						state_nxt = erz_pkg::ERZ_LK_DONE;
					end
					sel_ok_nxt = 1'b0;
				end
				erz_pkg::ERZ_FZ_ADDR: begin
					// fixed freeze address, anything else abandons
					if (i_byte == erz_pkg::FREEZE_ADDR) begin
						nack_nxt = 1'b0;
						state_nxt = erz_pkg::ERZ_FZ_DATA;
					end
				end
				erz_pkg::ERZ_FZ_DATA: begin
					// fixed freeze data, anything else abandons
					if (i_byte == erz_pkg::FREEZE_DATA) begin
						nack_nxt = 1'b0;
						state_nxt = erz_pkg::ERZ_FZ_DONE;
					end
				end
				erz_pkg::ERZ_AW_ADDR: begin
					// word address is taken even inside a locked zone
					nack_nxt = 1'b0;
					addr_nxt = i_byte[erz_pkg::ARR_AW-1:0];
					state_nxt = erz_pkg::ERZ_AW_DATA;
				end
				erz_pkg::ERZ_AW_DATA: begin
					// locked zones refuse the byte; open ones write and advance
					if (i_nv_lock[zone]) begin
						nack_nxt = 1'b1;
					end else begin
						nack_nxt = 1'b0;
						wr_en_nxt = 1'b1;
						data_nxt = i_byte;
						addr_nxt = addr_r + 7'h01;
						state_nxt = erz_pkg::ERZ_AW_DATA;
					end
				end
				default: begin
					// unframed or abandoned bytes get no answer
					ack_valid_nxt = 1'b0;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= erz_pkg::ERZ_IDLE;
			cnt_r <= '0;
			sel_r <= erz_pkg::LOCK_RESET;
			sel_ok_r <= 1'b0;
			ack_valid_r <= 1'b0;
			nack_r <= 1'b1;
			rd_valid_r <= 1'b0;
			rd_data_r <= erz_pkg::RD_UNLOCKED;
			set_lock_r <= 1'b0;
			set_freeze_r <= 1'b0;
			wr_en_r <= 1'b0;
			addr_r <= '0;
			data_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sel_r <= sel_nxt;
			sel_ok_r <= sel_ok_nxt;
			ack_valid_r <= ack_valid_nxt;
			nack_r <= nack_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			set_lock_r <= set_lock_nxt;
			set_freeze_r <= set_freeze_nxt;
			wr_en_r <= wr_en_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	// busy mirrors the next engine state; the port address is the byte written
	always_comb begin
		busy_nxt = (state_nxt == erz_pkg::ERZ_BUSY);
		waddr_nxt = waddr_r;
		if (wr_en_nxt) begin
			waddr_nxt = addr_r;
		end
	end

	// output copy registers; address reads all ones before the first write
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			waddr_r <= '1;
		end else begin
			busy_r <= busy_nxt;
			waddr_r <= waddr_nxt;
		end
	end

	// answer ports straight from flops
	assign o_ack_valid = ack_valid_r;
	assign o_nack = nack_r;
	assign o_rd_valid = rd_valid_r;
	assign o_rd_data = rd_data_r;
	assign o_busy = busy_r;
	// nonvolatile and array ports straight from flops
	assign o_nv_set_lock = set_lock_r;
	assign o_nv_lock_sel = sel_r;
	assign o_nv_set_freeze = set_freeze_r;
	assign o_arr_wr_en = wr_en_r;
	assign o_arr_addr = waddr_r;
	assign o_arr_data = data_r;
endmodule : erz_zone_lock

// ===== bench/erz_master_model.sv
// single-wire master model handing framed events to the lock engine
`timescale 1ns/1ps
module erz_master_model (
	// clock
	input wire logic i_clk,
	// framed events
	output logic o_start,
	output logic o_stop,
	output logic o_byte_valid,
	output logic [7:0] o_byte
);
	// idle: no strobe
	initial begin
		o_start = 1'b0;
		o_stop = 1'b0;
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
	end
	// one event a call, 0 start, 1 stop, 2 byte; line released otherwise
	task automatic ev(input int k, input logic [7:0] v);
		@(negedge i_clk);
		o_start = (k == 0);
		o_stop = (k == 1);
		o_byte_valid = (k == 2);
		o_byte = v;
		@(negedge i_clk);
		o_start = 1'b0;
		o_stop = 1'b0;
		o_byte_valid = 1'b0;
		o_byte = ~v; // stale byte never repeats
	endtask : ev
endmodule : erz_master_model

// ===== bench/erz_zone_lock_assertions.sv
// assertions for the zone lock engine
`timescale 1ns/1ps
module erz_zone_lock_assertions #(
	parameter int WR_CYCLES = erz_pkg::SELF_TIMED_WRITE_CYCLES
) (
	// clock, reset and inputs
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_stop,
	input wire logic i_byte_valid,
	input wire logic [3:0] i_nv_lock,
	input wire logic i_nv_frozen,
	// outputs
	input wire logic o_ack_valid,
	input wire logic o_nack,
	input wire logic o_rd_valid,
	input wire logic [7:0] o_rd_data,
	input wire logic o_busy,
	input wire logic o_nv_set_lock,
	input wire logic [3:0] o_nv_lock_sel,
	input wire logic o_nv_set_freeze,
	input wire logic o_arr_wr_en,
	input wire logic [6:0] o_arr_addr
);
	int cnt_r;
	int cnt_nxt;
	// busy cycle counter
	always_comb cnt_nxt = o_busy ? cnt_r + 1 : 0;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) cnt_r <= 0;
		else cnt_r <= cnt_nxt;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	ack_cause_a: assert property (o_ack_valid |-> $past(i_byte_valid))
		else $error("answer without byte");
	busy_quiet_a: assert property (o_busy |-> !o_ack_valid)
		else $error("answer while busy");
	busy_len_a: assert property ($fell(o_busy) |-> cnt_r == WR_CYCLES)
		else $error("busy length wrong");
	lock_stop_a: assert property (o_nv_set_lock |-> $past(i_stop) && o_busy)
		else $error("lock write not after stop");
	lock_frz_a: assert property (o_nv_set_lock |-> !i_nv_frozen)
		else $error("lock write while frozen");
	lock_sel_a: assert property (o_nv_set_lock |-> $onehot(o_nv_lock_sel))
		else $error("lock select not one-hot");
	frz_stop_a: assert property (o_nv_set_freeze |-> $past(i_stop) && !i_nv_frozen)
		else $error("bad freeze write");
	rd_value_a: assert property (o_rd_valid |-> !o_nack && o_rd_data inside {8'h00, 8'hff})
		else $error("bad lock read");
	arr_guard_a: assert property (o_arr_wr_en |-> !i_nv_lock[o_arr_addr[6:5]])
		else $error("write into locked zone");
	cover property (o_nv_set_lock);
	cover property (o_nv_set_freeze);
	cover property (o_rd_valid && o_rd_data == 8'hff);
endmodule : erz_zone_lock_assertions
bind erz_zone_lock erz_zone_lock_assertions #(.WR_CYCLES(WR_CYCLES)) u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_stop(i_stop), .i_byte_valid(i_byte_valid),
	.i_nv_lock(i_nv_lock), .i_nv_frozen(i_nv_frozen), .o_ack_valid(o_ack_valid),
	.o_nack(o_nack), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_busy(o_busy),
	.o_nv_set_lock(o_nv_set_lock), .o_nv_lock_sel(o_nv_lock_sel),
	.o_nv_set_freeze(o_nv_set_freeze), .o_arr_wr_en(o_arr_wr_en), .o_arr_addr(o_arr_addr));

// ===== bench/erz_zone_lock_tb.sv
// self-checking bench for the zone lock engine
`timescale 1ns/1ps
module erz_zone_lock_tb;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic st, sp, bv, ackv, nack, rdv, busy, setl, setf, wen;
	logic frz = 1'b0;
	logic [7:0] b, rdd, wd;
	logic [3:0] sel;
	logic [3:0] lk = 4'h0;
	logic [6:0] wa;
	int num_errors = 0;
	int compares = 0;
	// 200 MHz clock
	always #2.5 i_clk = ~i_clk;
	// nonvolatile cells, untouched by reset
	always @(posedge i_clk) begin
		if (setl) lk <= lk | sel;
		if (setf) frz <= 1'b1;
	end
	erz_master_model m (.i_clk(i_clk), .o_start(st), .o_stop(sp), .o_byte_valid(bv), .o_byte(b));
	erz_zone_lock #(.WR_CYCLES(8), .SLAVE_ADDR(3'h0)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_start(st), .i_stop(sp), .i_byte_valid(bv), .i_byte(b), .o_ack_valid(ackv),
		.o_nack(nack), .o_rd_valid(rdv), .o_rd_data(rdd), .o_busy(busy), .i_nv_lock(lk),
		.i_nv_frozen(frz), .o_nv_set_lock(setl), .o_nv_lock_sel(sel), .o_nv_set_freeze(setf),
		.o_arr_wr_en(wen), .o_arr_addr(wa), .o_arr_data(wd));
	task automatic results();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// send a byte and judge its answer while the one-cycle pulse stands
	task automatic xb(input logic [7:0] v, input logic e);
		m.ev(2, v);
		chk("ack_valid", 8'h01, ackv);
		chk("nack", e, nack);
	endtask : xb
	task automatic wt();
		for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge i_clk);
		chk("busy", 8'h00, busy);
	endtask : wt
	task automatic s_query(input logic [7:0] a, input logic [7:0] e);
		m.ev(0, 8'h00);
		xb(8'h70, 1'b0);
		xb(a, 1'b0);
		m.ev(0, 8'h00);
		m.ev(2, 8'h71);
		chk("rd_ack", 8'h01, ackv);
		chk("rd_nack", 8'h00, nack);
		chk("rd_valid", 8'h01, rdv);
		chk("rd_data", e, rdd);
	endtask : s_query
	task automatic s_set();
		m.ev(0, 8'h00);
		xb(8'h70, 1'b0);
		xb(8'h04, 1'b0);
		xb(8'hff, 1'b0);
		m.ev(1, 8'h00);
		@(negedge i_clk);
		chk("busy", 8'h01, busy);
		m.ev(0, 8'h00);
		m.ev(2, 8'h70);
		chk("ack_valid", 8'h00, ackv);
		chk("lock", 8'h04, lk);
		wt();
	endtask : s_set
	task automatic s_abort();
		m.ev(0, 8'h00);
		m.ev(2, 8'h72);
		chk("ack_other_slave", 8'h00, ackv);
		m.ev(0, 8'h00);
		xb(8'h70, 1'b0);
		xb(8'h03, 1'b1);
		m.ev(1, 8'h00);
		m.ev(0, 8'h00);
		xb(8'h70, 1'b0);
		xb(8'h01, 1'b0);
		m.ev(1, 8'h00);
		@(negedge i_clk);
		chk("busy", 8'h00, busy);
		chk("lock", 8'h04, lk);
	endtask : s_abort
	task automatic s_arr(input logic [6:0] a, input logic e);
		m.ev(0, 8'h00);
		xb(8'ha0, 1'b0);
		xb({1'b0, a}, 1'b0);
		xb(8'h5a, e);
		chk("wr_en", {7'h00, !e}, wen);
		if (!e) chk("arr_addr", {1'b0, a}, wa);
		if (!e) chk("arr_data", 8'h5a, wd);
		m.ev(1, 8'h00);
	endtask : s_arr
	task automatic s_freeze();
		m.ev(0, 8'h00);
		xb(8'h10, 1'b0);
		xb(8'h56, 1'b1);
		m.ev(1, 8'h00);
		m.ev(0, 8'h00);
		xb(8'h10, 1'b0);
		xb(8'h55, 1'b0);
		xb(8'haa, 1'b0);
		m.ev(1, 8'h00);
		wt();
		chk("frozen", 8'h01, frz);
		m.ev(0, 8'h00);
		xb(8'h10, 1'b1);
		m.ev(0, 8'h00);
		xb(8'h70, 1'b0);
		xb(8'h01, 1'b0);
		xb(8'hff, 1'b1);
		m.ev(1, 8'h00);
	endtask : s_freeze
	// watchdog
	initial begin
		#20000;
		num_errors++;
		results();
	end
	// main sequence
	initial begin
		repeat (10) @(negedge i_clk);
		i_rst_n = 1'b1;
		s_query(8'h02, 8'h00);
		s_set();
		s_query(8'hf4, 8'hff);
		s_abort();
		s_arr(7'h45, 1'b1);
		s_arr(7'h3f, 1'b0);
		s_arr(7'h60, 1'b0);
		i_rst_n = 1'b0;
		@(negedge i_clk);
		i_rst_n = 1'b1;
		s_query(8'h04, 8'hff);
		s_freeze();
		s_query(8'h01, 8'h00);
		results();
	end
endmodule : erz_zone_lock_tb
